// ---- hw/psc_pkg.sv ----
// Purpose: shared constants and types of the proximity sense control block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   register data sits in the low byte, upper bits read as zero
package psc_pkg;

	// ==================================================================
	// register byte offsets
	localparam logic [7:0] OFS_SWITCH_BANK_A  = 8'h00;
	localparam logic [7:0] OFS_SWITCH_BANK_B  = 8'h04;
	localparam logic [7:0] OFS_SWITCH_BANK_C  = 8'h08;
	localparam logic [7:0] OFS_SWITCH_BANK_D  = 8'h0C;
	localparam logic [7:0] OFS_SENSE_CONTROL_0 = 8'h10;
	localparam logic [7:0] OFS_SENSE_CONTROL_1 = 8'h14;
	localparam logic [7:0] OFS_DAC_LEVEL      = 8'h18;
	localparam logic [7:0] OFS_AMP0_TRIM      = 8'h1C;
	localparam logic [7:0] OFS_AMP1_TRIM      = 8'h20;
	localparam logic [7:0] OFS_CMP_TRIM       = 8'h24;

	// ==================================================================
	// reset values
	localparam logic [7:0] RST_ZERO      = 8'h00;
	localparam logic [7:0] RST_AMP_TRIM  = 8'h20;
	localparam logic [6:0] RST_CMP_TRIM  = 7'h10;

	// ==================================================================
	// field layout
	localparam logic [7:0] SWD_MASK      = 8'h1F;
	localparam int         C0_AMP1_EN    = 7;
	localparam int         C0_AMP0_EN    = 6;
	localparam int         C0_CMP_EN     = 5;
	localparam int         C0_EDGE_HI    = 4;
	localparam int         C0_EDGE_LO    = 3;
	localparam int         C0_DEB_HI     = 2;
	localparam int         C1_AMP1_CAL   = 7;
	localparam int         C1_AMP0_CAL   = 6;
	localparam logic [7:0] C1_WR_MASK    = 8'h3F;
	localparam int         CC_DECISION   = 7;
	localparam int         AUX_ROUTE     = 0;
	localparam int         AUX_IRQ_FLAG  = 1;
	localparam logic [7:0] OFS_AUX       = 8'h28;

	// ==================================================================
	// edge select encoding
	typedef enum logic [1:0] {
		PSC_EDGE_OFF  = 2'h0,
		PSC_EDGE_RISE = 2'h1,
		PSC_EDGE_FALL = 2'h2,
		PSC_EDGE_BOTH = 2'h3
	} psc_edge_t;

	// analog control bundle
	typedef struct packed {
		logic [28:0] analog_switch;
		logic        amp0_enable;
		logic        amp1_enable;
		logic        comparator_dac_enable;
		logic [1:0]  hysteresis_select;
		logic [1:0]  comparator_bias_select;
		logic        amp0_bandwidth_select;
		logic        amp1_bandwidth_select;
		logic [7:0]  dac_level;
		logic [7:0]  amp0_trim;
		logic [7:0]  amp1_trim;
		logic [6:0]  cmp_trim;
	} psc_analog_t;

endpackage : psc_pkg

// ---- hw/psc_top.sv ----
// Purpose: register bank, comparator filter and edge interrupt
// Assumes: comparator and amp cal outputs arrive asynchronously
// Notes:   debounce counts system clocks; stray APB writes are dropped
//
// Notes on behaviour
// - bank A holds eight switch controls, 1 closes, reset to zero
// - bank B holds eight more switch controls, same encoding, reset zero
// - bank D keeps five low bits; top three read as zero
// - raw comparator is filtered into a stable readable decision bit
// - two-bit field in control 0 picks the interrupting edge
// - edge code 00 off, 01 rising, 10 falling, 11 both
// - debounce 000 bypasses; code n needs about 2^n stable clocks
// - enabled edge of filtered decision raises the interrupt request
// - route bit feeds the debounced decision to the timer capture input
// - control 0 holds amp enables, comparator/DAC enable, debounce select
// - control 1 holds hysteresis, bias and per-amp bandwidth selects
// - eight-bit level register sets the comparator reference DAC code
// - per amp and comparator trim registers hold mode, reference, code
// - decision bit reads zero while the comparator is disabled
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module psc_top (
	input  wire logic         clock_in,      // system clock 50 MHz
	input  wire logic         rst_in,        // sync reset, high
	input  wire logic         psel_in,       // apb select
	input  wire logic         penable_in,    // apb enable
	input  wire logic         pwrite_in,     // apb direction
	input  wire logic [7:0]   paddr_in,      // apb byte address
	input  wire logic [31:0]  pwdata_in,     // apb write data
	input  wire logic         cmp_raw_in,    // raw comparator, async
	input  wire logic         amp0_cal_in,   // amp0 cal output, async
	input  wire logic         amp1_cal_in,   // amp1 cal output, async
	input  wire logic         capture_pin_in, // external capture pin
	output logic [31:0]       prdata_out,    // apb read data
	output logic              pready_out,    // apb ready
	output logic              pslverr_out,   // apb error
	output psc_pkg::psc_analog_t analog_out, // analog controls
	output logic              proximity_interrupt_out, // irq level
	output logic              timer_capture_input_out  // to timer
);

	// ==================================================================
	// registers
	logic [7:0]  bank_a_r, bank_b_r, bank_c_r, bank_d_r;
	logic [7:0]  ctl0_r, ctl1_r, dac_r, amp0_trim_r, amp1_trim_r;
	logic [6:0]  cmp_trim_r;
	logic        route_r;
	logic        irq_flag_r;
	logic [2:0]  cmp_sync_r, a0_sync_r, a1_sync_r, pin_sync_r;
	logic        cmp_clean_r, a0_clean_r, a1_clean_r, pin_clean_r;
	logic [6:0]  deb_cnt_r;
	logic        decision_r;
	logic        decision_d_r;
	logic        wr_acc;
	logic        rd_acc;
	logic        hit;
	logic [7:0]  rd_byte;
	logic [6:0]  deb_limit;
	logic        rise_ev, fall_ev, edge_ev, clr_req;
	psc_pkg::psc_edge_t edge_sel;

	assign wr_acc = psel_in && penable_in && pwrite_in;
	assign rd_acc = psel_in && !penable_in && !pwrite_in;
	assign edge_sel = psc_pkg::psc_edge_t'(ctl0_r[psc_pkg::C0_EDGE_HI:
		psc_pkg::C0_EDGE_LO]);

	// ==================================================================
	// register writes, one word per register
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			bank_a_r    <= psc_pkg::RST_ZERO;
			bank_b_r    <= psc_pkg::RST_ZERO;
			bank_c_r    <= psc_pkg::RST_ZERO;
			bank_d_r    <= psc_pkg::RST_ZERO;
			ctl0_r      <= psc_pkg::RST_ZERO;
			ctl1_r      <= psc_pkg::RST_ZERO;
			dac_r       <= psc_pkg::RST_ZERO;
			amp0_trim_r <= psc_pkg::RST_AMP_TRIM;
			amp1_trim_r <= psc_pkg::RST_AMP_TRIM;
			cmp_trim_r  <= psc_pkg::RST_CMP_TRIM;
			route_r     <= 1'b0;
		end
		else if (wr_acc)
		begin
			unique case (paddr_in)
				psc_pkg::OFS_SWITCH_BANK_A: bank_a_r <= pwdata_in[7:0];
				psc_pkg::OFS_SWITCH_BANK_B: bank_b_r <= pwdata_in[7:0];
				psc_pkg::OFS_SWITCH_BANK_C: bank_c_r <= pwdata_in[7:0];
				psc_pkg::OFS_SWITCH_BANK_D:
					bank_d_r <= pwdata_in[7:0] & psc_pkg::SWD_MASK;
				psc_pkg::OFS_SENSE_CONTROL_0: ctl0_r <= pwdata_in[7:0];
				psc_pkg::OFS_SENSE_CONTROL_1:
					ctl1_r <= pwdata_in[7:0] & psc_pkg::C1_WR_MASK;
				psc_pkg::OFS_DAC_LEVEL: dac_r <= pwdata_in[7:0];
				psc_pkg::OFS_AMP0_TRIM: amp0_trim_r <= pwdata_in[7:0];
				psc_pkg::OFS_AMP1_TRIM: amp1_trim_r <= pwdata_in[7:0];
				psc_pkg::OFS_CMP_TRIM: cmp_trim_r <= pwdata_in[6:0];
				psc_pkg::OFS_AUX: route_r <= pwdata_in[psc_pkg::AUX_ROUTE];
				default: ;
			endcase
		end
	end

	// ==================================================================
	// three-stage synchronisers; stage 0 is read only by stage 1
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			cmp_sync_r <= 3'h0;
			a0_sync_r  <= 3'h0;
			a1_sync_r  <= 3'h0;
			pin_sync_r <= 3'h0;
		end
		else
		begin
			cmp_sync_r <= {cmp_sync_r[1:0], cmp_raw_in};
			a0_sync_r  <= {a0_sync_r[1:0], amp0_cal_in};
			a1_sync_r  <= {a1_sync_r[1:0], amp1_cal_in};
			pin_sync_r <= {pin_sync_r[1:0], capture_pin_in};
		end
	end

	// a change counts only once stages one and two agree
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			cmp_clean_r <= 1'b0;
			a0_clean_r  <= 1'b0;
			a1_clean_r  <= 1'b0;
			pin_clean_r <= 1'b0;
		end
		else
		begin
			if (cmp_sync_r[1] == cmp_sync_r[2])
				cmp_clean_r <= cmp_sync_r[2];
			if (a0_sync_r[1] == a0_sync_r[2])
				a0_clean_r <= a0_sync_r[2];
			if (a1_sync_r[1] == a1_sync_r[2])
				a1_clean_r <= a1_sync_r[2];
			if (pin_sync_r[1] == pin_sync_r[2])
				pin_clean_r <= pin_sync_r[2];
		end
	end

	// ==================================================================
	// debounce: code n needs 2^n - 1 stable clocks in all
	assign deb_limit = 7'((8'h01 << ctl0_r[psc_pkg::C0_DEB_HI:0]) - 8'h01);

	always_ff @(posedge clock_in)
	begin
		if (rst_in || !ctl0_r[psc_pkg::C0_CMP_EN])
		begin
			deb_cnt_r  <= 7'h00;
			decision_r <= 1'b0;
		end
		else if (cmp_clean_r == decision_r)
			deb_cnt_r <= 7'h00;
		else if (ctl0_r[psc_pkg::C0_DEB_HI:0] == 3'h0)
			decision_r <= cmp_clean_r;
		else if (deb_cnt_r >= deb_limit - 7'h01)
		begin
			decision_r <= cmp_clean_r;
			deb_cnt_r  <= 7'h00;
		end
		else
			deb_cnt_r <= deb_cnt_r + 7'h01;
	end

	// ==================================================================
	// edge detect and sticky flag; a new edge beats a clear
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			decision_d_r <= 1'b0;
		else
			decision_d_r <= decision_r;
	end

	assign rise_ev = decision_r && !decision_d_r;
	assign fall_ev = !decision_r && decision_d_r;
	assign edge_ev = (rise_ev && edge_sel[0]) || (fall_ev && edge_sel[1]);
	assign clr_req = wr_acc && paddr_in == psc_pkg::OFS_AUX &&
		pwdata_in[psc_pkg::AUX_IRQ_FLAG];

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			irq_flag_r <= 1'b0;
		else if (edge_ev)
			irq_flag_r <= 1'b1;
		else if (clr_req)
			irq_flag_r <= 1'b0;
	end

	// ==================================================================
	// apb read mux; unmapped reads zero with error
	always_comb
	begin
		hit = 1'b1;
		rd_byte = 8'h00;
		unique case (paddr_in)
			psc_pkg::OFS_SWITCH_BANK_A: rd_byte = bank_a_r;
			psc_pkg::OFS_SWITCH_BANK_B: rd_byte = bank_b_r;
			psc_pkg::OFS_SWITCH_BANK_C: rd_byte = bank_c_r;
			psc_pkg::OFS_SWITCH_BANK_D: rd_byte = bank_d_r;
			psc_pkg::OFS_SENSE_CONTROL_0: rd_byte = ctl0_r;
			psc_pkg::OFS_SENSE_CONTROL_1:
				rd_byte = {a1_clean_r, a0_clean_r, ctl1_r[5:0]};
			psc_pkg::OFS_DAC_LEVEL: rd_byte = dac_r;
			psc_pkg::OFS_AMP0_TRIM: rd_byte = amp0_trim_r;
			psc_pkg::OFS_AMP1_TRIM: rd_byte = amp1_trim_r;
			psc_pkg::OFS_CMP_TRIM: rd_byte = {decision_r, cmp_trim_r};
			psc_pkg::OFS_AUX: rd_byte = {6'h00, irq_flag_r, route_r};
			default: hit = 1'b0;
		endcase
	end

	// no wait state: data registered in setup, ready in access
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			prdata_out  <= 32'h0000_0000;
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
		end
		else
		begin
			pready_out  <= psel_in && !penable_in;
			pslverr_out <= psel_in && !penable_in && !hit;
			if (rd_acc)
				prdata_out <= {24'h00_0000, rd_byte};
		end
	end

	// ==================================================================
	// outputs registered
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			analog_out              <= '0;
			proximity_interrupt_out <= 1'b0;
			timer_capture_input_out <= 1'b0;
		end
		else
		begin
			analog_out.analog_switch <= {bank_d_r[4:0], bank_c_r,
				bank_b_r, bank_a_r};
			analog_out.amp0_enable <= ctl0_r[psc_pkg::C0_AMP0_EN];
			analog_out.amp1_enable <= ctl0_r[psc_pkg::C0_AMP1_EN];
			analog_out.comparator_dac_enable <= ctl0_r[psc_pkg::C0_CMP_EN];
			analog_out.hysteresis_select <= ctl1_r[5:4];
			analog_out.comparator_bias_select <= ctl1_r[3:2];
			analog_out.amp1_bandwidth_select <= ctl1_r[1];
			analog_out.amp0_bandwidth_select <= ctl1_r[0];
			analog_out.dac_level <= dac_r;
			analog_out.amp0_trim <= amp0_trim_r;
			analog_out.amp1_trim <= amp1_trim_r;
			analog_out.cmp_trim  <= cmp_trim_r;
			proximity_interrupt_out <= irq_flag_r;
			timer_capture_input_out <= route_r ? decision_r
				: pin_clean_r;
		end
	end

	// ==================================================================
	// checks: register side
	a_bank_d_top: assert property (
		@(posedge clock_in) disable iff (rst_in)
		bank_d_r[7:5] == 3'h0) else $error("bank d top bits set");
	a_bank_a_wr: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(wr_acc && paddr_in == psc_pkg::OFS_SWITCH_BANK_A) |=>
		bank_a_r == $past(pwdata_in[7:0]))
		else $error("bank a write lost");
	a_bank_b_wr: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(wr_acc && paddr_in == psc_pkg::OFS_SWITCH_BANK_B) |=>
		bank_b_r == $past(pwdata_in[7:0]))
		else $error("bank b write lost");
	a_dac_wr: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(wr_acc && paddr_in == psc_pkg::OFS_DAC_LEVEL) |=>
		dac_r == $past(pwdata_in[7:0]))
		else $error("dac level write lost");

	// ==================================================================
	// checks: comparator decision
	a_dis_zero: assert property (
		@(posedge clock_in) disable iff (rst_in)
		!ctl0_r[psc_pkg::C0_CMP_EN] |=> !decision_r)
		else $error("decision set while disabled");
	a_dec_cause: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(ctl0_r[psc_pkg::C0_CMP_EN] && cmp_clean_r == decision_r) |=>
		$stable(decision_r)) else $error("decision moved without cause");
	a_bypass_fast: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(ctl0_r[2:0] == 3'h0 && ctl0_r[psc_pkg::C0_CMP_EN] &&
		$stable(ctl0_r) && cmp_clean_r != decision_r) |=> decision_r ==
		$past(cmp_clean_r)) else $error("bypass not immediate");
	// codes from 2 up never take a change on its first cycle
	sequence s_unstable;
		ctl0_r[2:1] != 2'h0 && $stable(ctl0_r) &&
		cmp_clean_r != decision_r && deb_cnt_r == 7'h00;
	endsequence
	a_deb_hold: assert property (
		@(posedge clock_in) disable iff (rst_in)
		s_unstable |=> $stable(decision_r))
		else $error("debounce too fast");

	// ==================================================================
	// checks: interrupt flag and request output
	a_edge_off: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(edge_sel == psc_pkg::PSC_EDGE_OFF && !irq_flag_r) |=>
		!irq_flag_r) else $error("irq with edges disabled");
	a_rise_irq: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(rise_ev && edge_sel == psc_pkg::PSC_EDGE_RISE) |=> irq_flag_r)
		else $error("rising edge missed");
	a_fall_irq: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(fall_ev && edge_sel == psc_pkg::PSC_EDGE_FALL) |=> irq_flag_r)
		else $error("falling edge missed");
	a_both_irq: assert property (
		@(posedge clock_in) disable iff (rst_in)
		((rise_ev || fall_ev) && edge_sel == psc_pkg::PSC_EDGE_BOTH) |=>
		irq_flag_r) else $error("edge missed in both mode");
	a_fall_only: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(rise_ev && edge_sel == psc_pkg::PSC_EDGE_FALL && !irq_flag_r)
		|=> !irq_flag_r) else $error("rise taken in fall mode");
	a_flag_hold: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(irq_flag_r && !clr_req) |=> irq_flag_r)
		else $error("flag dropped without clear");
	// the request pin trails the flag by one register
	sequence s_rise_taken;
		rise_ev && edge_sel == psc_pkg::PSC_EDGE_RISE;
	endsequence
	a_rise_out: assert property (
		@(posedge clock_in) disable iff (rst_in)
		s_rise_taken |=> ##1 proximity_interrupt_out)
		else $error("interrupt output missed");

	// ==================================================================
	// checks: capture route
	a_route_sel: assert property (
		@(posedge clock_in) disable iff (rst_in)
		route_r |=> timer_capture_input_out == $past(decision_r))
		else $error("capture route wrong");
	a_route_pin: assert property (
		@(posedge clock_in) disable iff (rst_in)
		!route_r |=> timer_capture_input_out == $past(pin_clean_r))
		else $error("capture pin path wrong");

endmodule : psc_top

// ---- verification/psc_top_tb.sv ----
// Purpose: self-checking bench of the proximity sense control block
// Assumes: apb slave answers within a few cycles of the access phase
// Notes:   comparator, cal and pin inputs are driven directly, no model
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
	$display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end

module psc_top_tb;
	logic                 clock_in;
	logic                 rst_in;
	logic                 psel_in;
	logic                 penable_in;
	logic                 pwrite_in;
	logic [7:0]           paddr_in;
	logic [31:0]          pwdata_in;
	logic                 cmp_raw_in;
	logic                 amp0_cal_in;
	logic                 amp1_cal_in;
	logic                 capture_pin_in;
	logic [31:0]          prdata_out;
	logic                 pready_out;
	logic                 pslverr_out;
	psc_pkg::psc_analog_t analog_out;
	logic                 proximity_interrupt_out;
	logic                 timer_capture_input_out;
	logic [31:0]          rd;
	logic                 er;
	int                   failures;
	int                   checked;
	int                   cycles;

	// ==================================================================
	// design under test
	psc_top DUT (
		.clock_in                (clock_in),
		.rst_in                  (rst_in),
		.psel_in                 (psel_in),
		.penable_in              (penable_in),
		.pwrite_in               (pwrite_in),
		.paddr_in                (paddr_in),
		.pwdata_in               (pwdata_in),
		.cmp_raw_in              (cmp_raw_in),
		.amp0_cal_in             (amp0_cal_in),
		.amp1_cal_in             (amp1_cal_in),
		.capture_pin_in          (capture_pin_in),
		.prdata_out              (prdata_out),
		.pready_out              (pready_out),
		.pslverr_out             (pslverr_out),
		.analog_out              (analog_out),
		.proximity_interrupt_out (proximity_interrupt_out),
		.timer_capture_input_out (timer_capture_input_out)
	);

	// ==================================================================
	// clock and hang guard
	initial
	begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end

	// whole run is under two thousand cycles, so this ceiling means a hang
	always @(posedge clock_in)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			wrap_up;
		end
	end

	// ==================================================================
	// shared tasks
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
	endtask : tick

	// one apb transfer; the leading edge keeps psel from a double drive
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clock_in);
		psel_in    <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in  <= wr;
		paddr_in   <= a;
		pwdata_in  <= d;
		@(posedge clock_in);
		penable_in <= 1'b1;
		@(posedge clock_in);
		while (pready_out !== 1'b1)
			@(posedge clock_in);
		rd = prdata_out;
		er = pslverr_out;
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask : rchk

	task automatic wrap_up;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up

	// ==================================================================
	// scenarios
	task automatic t_reset;
		rchk(psc_pkg::OFS_SWITCH_BANK_A, 32'h00);
		rchk(psc_pkg::OFS_SWITCH_BANK_B, 32'h00);
		rchk(psc_pkg::OFS_SENSE_CONTROL_0, 32'h00);
		rchk(psc_pkg::OFS_AMP0_TRIM, 32'h20);
		rchk(psc_pkg::OFS_CMP_TRIM, 32'h10);
		`CHK(analog_out.analog_switch, 29'h0)
		$display("test reset values done");
	endtask : t_reset

	task automatic t_regs;
		apb(1'b1, psc_pkg::OFS_SWITCH_BANK_A, 32'hA5);
		apb(1'b1, psc_pkg::OFS_SWITCH_BANK_B, 32'h5A);
		apb(1'b1, psc_pkg::OFS_SWITCH_BANK_C, 32'h3C);
		apb(1'b1, psc_pkg::OFS_SWITCH_BANK_D, 32'hFF);
		apb(1'b1, psc_pkg::OFS_SENSE_CONTROL_0, 32'hC0);
		apb(1'b1, psc_pkg::OFS_SENSE_CONTROL_1, 32'hFF);
		apb(1'b1, psc_pkg::OFS_DAC_LEVEL, 32'hFF);
		apb(1'b1, psc_pkg::OFS_AMP1_TRIM, 32'h9C);
		apb(1'b1, psc_pkg::OFS_CMP_TRIM, 32'hFF);
		rchk(psc_pkg::OFS_SWITCH_BANK_A, 32'hA5);
		rchk(psc_pkg::OFS_SWITCH_BANK_B, 32'h5A);
		rchk(psc_pkg::OFS_SWITCH_BANK_D, 32'h1F);
		rchk(psc_pkg::OFS_SENSE_CONTROL_0, 32'hC0);
		// amp0 cal input is held high, amp1 low
		rchk(psc_pkg::OFS_SENSE_CONTROL_1, 32'h7F);
		rchk(psc_pkg::OFS_DAC_LEVEL, 32'hFF);
		rchk(psc_pkg::OFS_AMP1_TRIM, 32'h9C);
		rchk(psc_pkg::OFS_CMP_TRIM, 32'h7F);
		`CHK(analog_out.analog_switch, {5'h1F, 8'h3C, 8'h5A, 8'hA5})
		`CHK(analog_out.amp0_enable, 1'b1)
		`CHK(analog_out.hysteresis_select, 2'h3)
		`CHK(analog_out.dac_level, 8'hFF)
		`CHK(analog_out.amp1_enable, 1'b1)
		`CHK(analog_out.comparator_dac_enable, 1'b0)
		`CHK(analog_out.comparator_bias_select, 2'h3)
		`CHK({analog_out.amp1_bandwidth_select,
			analog_out.amp0_bandwidth_select}, 2'h3)
		`CHK(analog_out.amp0_trim, 8'h20)
		`CHK(analog_out.amp1_trim, 8'h9C)
		`CHK(analog_out.cmp_trim, 7'h7F)
		apb(1'b0, 8'h3C, 32'h0);
		`CHK({er, rd}, 33'h1_0000_0000)
		$display("test register access done");
	endtask : t_regs

	// every edge code, debounce bypassed, flag cleared between edges
	task automatic t_edges;
		for (int c = 0; c < 4; c++)
		begin
			apb(1'b1, psc_pkg::OFS_SENSE_CONTROL_0, 32'(c << 3) | 32'h20);
			apb(1'b1, psc_pkg::OFS_AUX, 32'h2);
			cmp_raw_in <= 1'b1;
			tick(15);
			`CHK(proximity_interrupt_out, c[0])
			rchk(psc_pkg::OFS_CMP_TRIM, 32'hFF);
			`CHK(proximity_interrupt_out, c[0])
			apb(1'b1, psc_pkg::OFS_AUX, 32'h2);
			tick(2);
			`CHK(proximity_interrupt_out, 1'b0)
			cmp_raw_in <= 1'b0;
			tick(15);
			`CHK(proximity_interrupt_out, c[1])
		end
		$display("test edge select done");
	endtask : t_edges

	// a pulse just short of the window is swallowed, a long one passes
	task automatic t_deb(input int code, input int shrt, input int lng);
		apb(1'b1, psc_pkg::OFS_SENSE_CONTROL_0, 32'h28 | 32'(code));
		apb(1'b1, psc_pkg::OFS_AUX, 32'h2);
		cmp_raw_in <= 1'b1;
		tick(shrt);
		cmp_raw_in <= 1'b0;
		tick(lng);
		`CHK(proximity_interrupt_out, 1'b0)
		cmp_raw_in <= 1'b1;
		tick(lng);
		`CHK(proximity_interrupt_out, 1'b1)
		cmp_raw_in <= 1'b0;
		tick(lng);
		$display("test debounce code %0d done", code);
	endtask : t_deb

	task automatic t_route;
		apb(1'b1, psc_pkg::OFS_SENSE_CONTROL_0, 32'h20);
		cmp_raw_in <= 1'b1;
		apb(1'b1, psc_pkg::OFS_AUX, 32'h1);
		tick(10);
		`CHK(timer_capture_input_out, 1'b1)
		// flag left set by the last debounce run, route now selected
		rchk(psc_pkg::OFS_AUX, 32'h3);
		apb(1'b1, psc_pkg::OFS_AUX, 32'h0);
		tick(3);
		`CHK(timer_capture_input_out, 1'b0)
		capture_pin_in <= 1'b1;
		tick(8);
		`CHK(timer_capture_input_out, 1'b1)
		// disable with the raw input still high
		apb(1'b1, psc_pkg::OFS_SENSE_CONTROL_0, 32'h00);
		tick(10);
		rchk(psc_pkg::OFS_CMP_TRIM, 32'h7F);
		cmp_raw_in <= 1'b0;
		$display("test capture route and disable done");
	endtask : t_route

	// ==================================================================
	// main sequence
	initial
	begin
		rst_in         = 1'b1;
		psel_in        = 1'b0;
		penable_in     = 1'b0;
		pwrite_in      = 1'b0;
		paddr_in       = 8'h00;
		pwdata_in      = 32'h0;
		cmp_raw_in     = 1'b0;
		amp0_cal_in    = 1'b1;
		amp1_cal_in    = 1'b0;
		capture_pin_in = 1'b0;
		failures       = 0;
		checked        = 0;
		cycles         = 0;
		repeat (12) @(posedge clock_in);
		rst_in <= 1'b0;
		t_reset;
		t_regs;
		t_edges;
		for (int n = 2; n <= 7; n++)
			t_deb(n, (1 << n) - 3, (1 << n) + 20);
		t_route;
		wrap_up;
	end
endmodule : psc_top_tb
